//--- hw/rrc_pkg.sv
package rrc_pkg;

	// ------------------------------------------------------------
	// Bus geometry
	// ------------------------------------------------------------
	localparam int ADDR_W  = 8;
	localparam int DATA_W  = 32;
	localparam int NUM_CH  = 4;

	// ------------------------------------------------------------
	// Register indices and byte addresses
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] IDX_REF_SEL    = 8'h19;
	localparam logic [ADDR_W-1:0] IDX_ALARM_CTRL = 8'h1A;
	localparam logic [ADDR_W-1:0] IDX_STATUS     = 8'h1B;
	localparam logic [ADDR_W-1:0] ADDR_REF_SEL    = 8'(IDX_REF_SEL * 4);
	localparam logic [ADDR_W-1:0] ADDR_ALARM_CTRL = 8'(IDX_ALARM_CTRL * 4);
	localparam logic [ADDR_W-1:0] ADDR_STATUS     = 8'(IDX_STATUS * 4);

	// ------------------------------------------------------------
	// Reference select fields
	// ------------------------------------------------------------
	localparam int REF_B_SEL_HI  = 7;
	localparam int REF_B_SEL_LO  = 6;
	localparam int REF_B_EN_BIT  = 5;
	localparam int FULL_RATE_BIT = 4;
	localparam int REF_A_EN_BIT  = 3;
	localparam int REF_A_SEL_HI  = 1;
	localparam int REF_A_SEL_LO  = 0;
	localparam logic [7:0] REF_SEL_RESET = 8'h00;
	localparam logic [7:0] REF_SEL_MASK  = 8'hFB;

	// ------------------------------------------------------------
	// Alarm control: channel n uses bits 2n+1 (enable), 2n (polarity)
	// ------------------------------------------------------------
	localparam int ALARM_EN_OFS  = 1;
	localparam int ALARM_POL_OFS = 0;
	localparam logic [7:0] ALARM_CTRL_RESET = 8'h00;

	// ------------------------------------------------------------
	// Status fields
	// ------------------------------------------------------------
	localparam int STAT_LOSS_LO = 0;
	localparam int STAT_EXT_LO  = 4;

	// ------------------------------------------------------------
	// Divider and responses
	// ------------------------------------------------------------
	localparam int DIV_RATIO = 256;
	localparam int DIV_W     = $clog2(DIV_RATIO);
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- hw/rrc_ref_clock_select.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Output B follows the line clock of the channel picked by bits 7-6.
// - Output B drives only while bit 5 is set, else high impedance.
// - Enabled output B goes low on loss of signal of its channel.
// - Bit 4 set passes the line clock; clear divides it by 256.
// - Output A drives only while bit 3 is set, else high impedance.
// - Enabled output A goes low on loss of signal of its channel.
// - Output A follows the line clock of the channel picked by bits 1-0.
// - Enabled external alarm ORs into loss and tri-states enabled outputs that select its channel.
// - Polarity bit 1 means low alarm input is active; 0 means high.
module rrc_ref_clock_select (
	// Clock and reset
	input  wire  logic                        mclk,
	input  wire  logic                        reset,
	// AXI4-Lite write address
	input  wire  logic [rrc_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire  logic                        s_axi_awvalid,
	output logic                              s_axi_awready,
	// AXI4-Lite write data
	input  wire  logic [rrc_pkg::DATA_W-1:0]  s_axi_wdata,
	input  wire  logic [3:0]                  s_axi_wstrb,
	input  wire  logic                        s_axi_wvalid,
	output logic                              s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                        s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire  logic                        s_axi_bready,
	// AXI4-Lite read address
	input  wire  logic [rrc_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire  logic                        s_axi_arvalid,
	output logic                              s_axi_arready,
	// AXI4-Lite read data
	output logic [rrc_pkg::DATA_W-1:0]        s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire  logic                        s_axi_rready,
	// Channel inputs
	input  wire  logic [rrc_pkg::NUM_CH-1:0]  line_rx_clock,
	input  wire  logic [rrc_pkg::NUM_CH-1:0]  signal_loss,
	input  wire  logic [rrc_pkg::NUM_CH-1:0]  ext_alarm_input,
	// Reference outputs
	output logic                              ref_out_a,
	output logic                              ref_out_a_oe,
	output logic                              ref_out_b,
	output logic                              ref_out_b_oe
);
	import rrc_pkg::*;

	// ------------------------------------------------------------
	// Selection helper
	// ------------------------------------------------------------
	function automatic logic pick_chan(input logic [NUM_CH-1:0] v, input logic [1:0] s);
		pick_chan = v[s];
	endfunction

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0]        ref_sel_reg;
	logic [7:0]        alarm_ctrl_reg;
	logic [NUM_CH-1:0] line_prev_reg;
	logic [DIV_W-1:0]  div_cnt_reg [NUM_CH];
	logic              aw_got_reg;
	logic              w_got_reg;
	logic [ADDR_W-1:0] waddr_reg;
	logic [7:0]        wdata_reg;
	logic              wlane_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic              rvalid_reg;
	logic [1:0]        rresp_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic              out_a_reg;
	logic              oe_a_reg;
	logic              out_b_reg;
	logic              oe_b_reg;

	// ------------------------------------------------------------
	// Per-channel alarm and divider
	// ------------------------------------------------------------
	logic [NUM_CH-1:0] ext_active;
	logic [NUM_CH-1:0] chan_loss;
	logic [NUM_CH-1:0] chan_ext;
	logic [NUM_CH-1:0] div_clk;
	logic [NUM_CH-1:0] line_rise;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_chan
			assign ext_active[gi] = ext_alarm_input[gi] ^ alarm_ctrl_reg[2*gi+ALARM_POL_OFS];
			assign chan_ext[gi]   = alarm_ctrl_reg[2*gi+ALARM_EN_OFS] & ext_active[gi];
			assign chan_loss[gi]  = signal_loss[gi] | chan_ext[gi];
			assign line_rise[gi]  = line_rx_clock[gi] & ~line_prev_reg[gi];
			assign div_clk[gi]    = div_cnt_reg[gi][DIV_W-1];

			// Counts line edges, so the top bit is a 50 % duty 1/256 clock
			always_ff @(posedge mclk or posedge reset) begin
				if (reset)
					div_cnt_reg[gi] <= '0;
				else if (line_rise[gi])
					div_cnt_reg[gi] <= div_cnt_reg[gi] + 1'b1;
			end
		end
	endgenerate

	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			line_prev_reg <= '0;
		else
			line_prev_reg <= line_rx_clock;
	end

	// ------------------------------------------------------------
	// Output path
	// ------------------------------------------------------------
	wire [1:0] sel_a     = ref_sel_reg[REF_A_SEL_HI:REF_A_SEL_LO];
	wire [1:0] sel_b     = ref_sel_reg[REF_B_SEL_HI:REF_B_SEL_LO];
	wire       full_rate = ref_sel_reg[FULL_RATE_BIT];
	wire       en_a      = ref_sel_reg[REF_A_EN_BIT];
	wire       en_b      = ref_sel_reg[REF_B_EN_BIT];
	wire       src_a     = full_rate ? pick_chan(line_rx_clock, sel_a)
	                                 : pick_chan(div_clk, sel_a);
	wire       src_b     = full_rate ? pick_chan(line_rx_clock, sel_b)
	                                 : pick_chan(div_clk, sel_b);
	wire       loss_a    = pick_chan(chan_loss, sel_a);
	wire       loss_b    = pick_chan(chan_loss, sel_b);
	wire       ext_a     = pick_chan(chan_ext, sel_a);
	wire       ext_b     = pick_chan(chan_ext, sel_b);
	wire       out_a_next = en_a & ~loss_a & src_a;
	wire       out_b_next = en_b & ~loss_b & src_b;
	wire       oe_a_next  = en_a & ~ext_a;
	wire       oe_b_next  = en_b & ~ext_b;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			out_a_reg <= 1'b0;
			oe_a_reg  <= 1'b0;
			out_b_reg <= 1'b0;
			oe_b_reg  <= 1'b0;
		end else begin
			out_a_reg <= out_a_next;
			oe_a_reg  <= oe_a_next;
			out_b_reg <= out_b_next;
			oe_b_reg  <= oe_b_next;
		end
	end

	assign ref_out_a    = out_a_reg;
	assign ref_out_a_oe = oe_a_reg;
	assign ref_out_b    = out_b_reg;
	assign ref_out_b_oe = oe_b_reg;

	// ------------------------------------------------------------
	// AXI4-Lite write side
	// ------------------------------------------------------------
	wire aw_take   = s_axi_awvalid & s_axi_awready;
	wire w_take    = s_axi_wvalid & s_axi_wready;
	wire wr_commit = aw_got_reg & w_got_reg & ~bvalid_reg;
	wire wr_sel    = wr_commit & wlane_reg & (waddr_reg == ADDR_REF_SEL);
	wire wr_alarm  = wr_commit & wlane_reg & (waddr_reg == ADDR_ALARM_CTRL);
	wire wr_mapped = (waddr_reg == ADDR_REF_SEL) | (waddr_reg == ADDR_ALARM_CTRL)
	               | (waddr_reg == ADDR_STATUS);

	assign s_axi_awready = ~aw_got_reg & ~bvalid_reg;
	assign s_axi_wready  = ~w_got_reg & ~bvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			aw_got_reg <= 1'b0;
			waddr_reg  <= '0;
		end else if (aw_take) begin
			aw_got_reg <= 1'b1;
			waddr_reg  <= s_axi_awaddr;
		end else if (wr_commit)
			aw_got_reg <= 1'b0;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			w_got_reg <= 1'b0;
			wdata_reg <= '0;
			wlane_reg <= 1'b0;
		end else if (w_take) begin
			w_got_reg <= 1'b1;
			wdata_reg <= s_axi_wdata[7:0];
			wlane_reg <= s_axi_wstrb[0];
		end else if (wr_commit)
			w_got_reg <= 1'b0;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else if (wr_commit) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready)
			bvalid_reg <= 1'b0;
	end

	// Reserved bit 2 is never stored, so it always reads back zero
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			ref_sel_reg <= REF_SEL_RESET;
		else if (wr_sel)
			ref_sel_reg <= wdata_reg & REF_SEL_MASK;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			alarm_ctrl_reg <= ALARM_CTRL_RESET;
		else if (wr_alarm)
			alarm_ctrl_reg <= wdata_reg;
	end

	// ------------------------------------------------------------
	// AXI4-Lite read side
	// ------------------------------------------------------------
	wire ar_take = s_axi_arvalid & s_axi_arready;
	// Raw alarm sense shows even while disabled, so wiring can be checked first
	wire [7:0] status_val = 8'({ext_active, 4'h0} | {4'h0, chan_loss});
	wire rd_sel   = (s_axi_araddr == ADDR_REF_SEL);
	wire rd_alarm = (s_axi_araddr == ADDR_ALARM_CTRL);
	wire rd_stat  = (s_axi_araddr == ADDR_STATUS);
	wire [7:0] rd_byte = rd_sel   ? ref_sel_reg :
	                     rd_alarm ? alarm_ctrl_reg :
	                     rd_stat  ? status_val : 8'h00;

	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= RESP_OKAY;
			rdata_reg  <= '0;
		end else if (ar_take) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= (rd_sel | rd_alarm | rd_stat) ? RESP_OKAY : RESP_SLVERR;
			rdata_reg  <= {24'h000000, rd_byte};
		end else if (s_axi_rready)
			rvalid_reg <= 1'b0;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_reset_clears_sel: assert property (@(posedge mclk) reset |=> ref_sel_reg == REF_SEL_RESET)
		else $error("select register not cleared in reset");
	chk_b_oe_follow: assert property (@(posedge mclk) disable iff (reset)
		!$past(en_b) |-> !ref_out_b_oe)
		else $error("output B driven while disabled");
	chk_a_oe_follow: assert property (@(posedge mclk) disable iff (reset)
		!$past(en_a) |-> !ref_out_a_oe)
		else $error("output A driven while disabled");
	chk_b_loss_low: assert property (@(posedge mclk) disable iff (reset)
		(en_b && loss_b) |=> !ref_out_b)
		else $error("output B not forced low on loss");
	chk_a_loss_low: assert property (@(posedge mclk) disable iff (reset)
		(en_a && loss_a) |=> !ref_out_a)
		else $error("output A not forced low on loss");
	chk_b_full_sel: assert property (@(posedge mclk) disable iff (reset)
		(en_b && full_rate && !loss_b) |=> ref_out_b == $past(line_rx_clock[sel_b]))
		else $error("output B not the selected line clock");
	chk_a_full_sel: assert property (@(posedge mclk) disable iff (reset)
		(en_a && full_rate && !loss_a) |=> ref_out_a == $past(line_rx_clock[sel_a]))
		else $error("output A not the selected line clock");
	chk_div_step: assert property (@(posedge mclk) disable iff (reset)
		line_rise[0] |=> div_cnt_reg[0] == $past(div_cnt_reg[0]) + 8'h01)
		else $error("divider missed a line edge");
	chk_ext_tristate: assert property (@(posedge mclk) disable iff (reset)
		(alarm_ctrl_reg[1] && ext_active[0] && sel_a == 2'h0) |=> !ref_out_a_oe)
		else $error("external alarm did not tri-state output A");
	chk_pol_sense: assert property (@(posedge mclk) disable iff (reset)
		(en_a && sel_a == 2'h0 && alarm_ctrl_reg[ALARM_EN_OFS]
		 && alarm_ctrl_reg[ALARM_POL_OFS] && !ext_alarm_input[0]) |=> !ref_out_a_oe)
		else $error("low-active alarm did not tri-state output A");
	chk_b_ext_tristate: assert property (@(posedge mclk) disable iff (reset)
		(en_b && ext_b) |=> !ref_out_b_oe && !ref_out_b)
		else $error("external alarm did not tri-state output B");
	chk_a_div_sel: assert property (@(posedge mclk) disable iff (reset)
		(en_a && !full_rate && !loss_a) |=> ref_out_a == $past(div_clk[sel_a]))
		else $error("output A not the divided line clock");
	chk_a_off_low: assert property (@(posedge mclk) disable iff (reset)
		!en_a |=> !ref_out_a)
		else $error("disabled output A not held low");
	chk_b_off_low: assert property (@(posedge mclk) disable iff (reset)
		!en_b |=> !ref_out_b)
		else $error("disabled output B not held low");

	// ------------------------------------------------------------
	// Cover points
	// ------------------------------------------------------------
	cov_full_rate_b: cover property (@(posedge mclk) disable iff (reset)
		en_b && full_rate ##1 ref_out_b ##1 !ref_out_b);
	cov_divided_a: cover property (@(posedge mclk) disable iff (reset)
		en_a && !full_rate && $rose(ref_out_a));
	cov_loss_a: cover property (@(posedge mclk) disable iff (reset) en_a && loss_a);
	cov_ext_cut: cover property (@(posedge mclk) disable iff (reset) $fell(ref_out_b_oe));
	cov_low_alarm: cover property (@(posedge mclk) disable iff (reset)
		en_a && alarm_ctrl_reg[ALARM_POL_OFS] && !ref_out_a_oe);

endmodule

//--- bench/rrc_line_partner.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Framer side: four free-running receive line clocks
// ------------------------------------------------------------
module rrc_line_partner (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       reset,
	// Channel n toggles every n+1 mclk cycles, so each lane is distinct
	output logic [3:0]      line_rx_clock
);
	logic [2:0] cnt_reg [4];

	// Line clocks run free; the recovered clock never stops between frames
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			line_rx_clock <= 4'h0;
			for (int i = 0; i < 4; i++) cnt_reg[i] <= 3'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (cnt_reg[i] == 3'(i)) begin
					cnt_reg[i] <= 3'h0;
					line_rx_clock[i] <= ~line_rx_clock[i];
				end else begin
					cnt_reg[i] <= cnt_reg[i] + 3'h1;
				end
			end
		end
	end
endmodule

//--- bench/recovered_reference_clock_select_tb.sv
`timescale 1ns/1ps
module recovered_reference_clock_select_tb;
	import rrc_pkg::*;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        mclk = 1'b0, reset = 1'b1;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awready, wready, bvalid, arready, rvalid, ra, ra_oe, rb, rb_oe;
	logic [1:0]  bresp, rresp;
	logic [3:0]  lclk, lclk_d, loss = 4'h0, alarm = 4'h0;
	logic [3:0]  wstrb = 4'hF;
	int          n_errors = 0, checked = 0;

	always #20 mclk = ~mclk;
	// Line level during the previous cycle, which is what the outputs show
	always @(posedge mclk) lclk_d <= lclk;

	rrc_ref_clock_select u_dut (.mclk(mclk), .reset(reset),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.line_rx_clock(lclk), .signal_loss(loss), .ext_alarm_input(alarm),
		.ref_out_a(ra), .ref_out_a_oe(ra_oe), .ref_out_b(rb), .ref_out_b_oe(rb_oe));
	rrc_line_partner u_line (.mclk(mclk), .reset(reset), .line_rx_clock(lclk));

	// ------------------------------------------------------------
	// Reporting
	// ------------------------------------------------------------
	task automatic wrap_up();
		$display("checked %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic bound(inout int n);
		n++;
		if (n > 100) begin
			n_errors++;
			$display("mismatch at %0t: bus wait timed out", $time);
			wrap_up();
		end
	endtask

	// ------------------------------------------------------------
	// AXI4-Lite master
	// ------------------------------------------------------------
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic pa, pd;
		n = 0;
		pa = 1'b1;
		pd = 1'b1;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pa || pd) begin
			@(posedge mclk);
			bound(n);
			if (pa && awready) begin
				pa = 1'b0;
				awvalid <= 1'b0;
			end
			if (pd && wready) begin
				pd = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge mclk);
			bound(n);
		end while (!bvalid);
		bready <= 1'b0;
		cmp(bresp, er, "bresp");
	endtask
	task automatic bus_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			bound(n);
		end while (!arready);
		arvalid <= 1'b0;
		do begin
			@(posedge mclk);
			bound(n);
		end while (!rvalid);
		rready <= 1'b0;
		cmp(rresp, er, "rresp");
		cmp(rdata, ed, "rdata");
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		bus_rd(ADDR_REF_SEL, 32'h0, RESP_OKAY);
		cmp({ra_oe, rb_oe, ra, rb}, 32'h0, "idle outputs");
		bus_rd(8'h00, 32'h0, RESP_SLVERR);
		bus_wr(8'h04, 32'hFF, RESP_SLVERR);
		bus_wr(ADDR_REF_SEL, 32'hFF, RESP_OKAY);
		bus_wr(ADDR_STATUS, 32'h00, RESP_OKAY);
		wstrb <= 4'h0;
		bus_wr(ADDR_REF_SEL, 32'h00, RESP_OKAY);
		wstrb <= 4'hF;
		bus_rd(ADDR_REF_SEL, 32'hFB, RESP_OKAY);
		$display("test reset done");
	endtask
	task automatic t_select();
		logic [7:0] d;
		for (int s = 0; s < 4; s++) begin
			d = 8'(((3 - s) << 6) | s) | 8'h38;
			bus_wr(ADDR_REF_SEL, {24'h0, d}, RESP_OKAY);
			repeat (2) @(posedge mclk);
			repeat (12) begin
				@(negedge mclk);
				cmp({ra_oe, ra}, {1'b1, lclk_d[s]}, "ref a");
				cmp({rb_oe, rb}, {1'b1, lclk_d[3 - s]}, "ref b");
			end
		end
		$display("test select done");
	endtask
	task automatic run_len(input logic lvl, output int c);
		c = 0;
		while (ra === lvl) begin
			@(negedge mclk);
			c++;
			if (c > 700) begin
				n_errors++;
				$display("mismatch at %0t: reference level stuck", $time);
				wrap_up();
			end
		end
	endtask
	task automatic t_divide();
		int c;
		bus_wr(ADDR_REF_SEL, 32'h08, RESP_OKAY);
		run_len(1'b1, c);
		run_len(1'b0, c);
		run_len(1'b1, c);
		// Channel 0 line period is two mclk: half of 256 line periods is 256 mclk
		cmp(c, 32'(DIV_RATIO), "divided high");
		run_len(1'b0, c);
		cmp(c, 32'(DIV_RATIO), "divided low");
		$display("test divide done");
	endtask
	task automatic t_loss();
		bus_wr(ADDR_REF_SEL, 32'hB9, RESP_OKAY);
		loss <= 4'b0010;
		repeat (3) @(posedge mclk);
		repeat (6) begin
			@(negedge mclk);
			cmp({ra_oe, ra, rb_oe, rb}, {3'b101, lclk_d[2]}, "loss on a");
		end
		@(posedge mclk);
		loss <= 4'b0100;
		repeat (3) @(posedge mclk);
		repeat (6) begin
			@(negedge mclk);
			cmp({rb_oe, rb, ra_oe, ra}, {3'b101, lclk_d[1]}, "loss on b");
		end
		@(posedge mclk);
		loss <= 4'h0;
		$display("test loss done");
	endtask
	task automatic t_alarm();
		// Each entry: enable, polarity, input level, expected drive
		logic [3:0] tbl [5] = '{4'b0011, 4'b1010, 4'b1001, 4'b1100, 4'b1111};
		logic [7:0] st;
		bus_wr(ADDR_REF_SEL, 32'h38, RESP_OKAY);
		foreach (tbl[i]) begin
			bus_wr(ADDR_ALARM_CTRL, {30'h0, tbl[i][3:2]}, RESP_OKAY);
			alarm <= {4{tbl[i][1]}};
			repeat (3) @(posedge mclk);
			@(negedge mclk);
			cmp({ra_oe, rb_oe}, {2{tbl[i][0]}}, "alarm drive");
			if (!tbl[i][0]) cmp({ra, rb}, 32'h0, "alarm level");
			bus_rd(ADDR_ALARM_CTRL, {30'h0, tbl[i][3:2]}, RESP_OKAY);
			// Raw sense: channel 0 follows polarity, the others are high-active
			st = {{3{tbl[i][1]}}, tbl[i][1] ^ tbl[i][2], 3'h0, ~tbl[i][0]};
			bus_rd(ADDR_STATUS, {24'h0, st}, RESP_OKAY);
		end
		bus_wr(ADDR_ALARM_CTRL, 32'h0, RESP_OKAY);
		alarm <= 4'h0;
		$display("test alarm done");
	endtask
	task automatic t_disable();
		bus_wr(ADDR_REF_SEL, 32'h30, RESP_OKAY);
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		cmp({ra_oe, ra, rb_oe}, 3'b001, "a off");
		bus_wr(ADDR_REF_SEL, 32'h18, RESP_OKAY);
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		cmp({rb_oe, rb, ra_oe}, 3'b001, "b off");
		$display("test disable done");
	endtask
	task automatic t_mid_reset();
		bus_wr(ADDR_REF_SEL, 32'h38, RESP_OKAY);
		@(posedge mclk);
		reset <= 1'b1;
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		@(negedge mclk);
		cmp({ra_oe, rb_oe, ra, rb}, 32'h0, "outputs after reset");
		bus_rd(ADDR_REF_SEL, 32'h0, RESP_OKAY);
		bus_rd(ADDR_ALARM_CTRL, 32'h0, RESP_OKAY);
		$display("test mid reset done");
	endtask

	initial begin
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		t_reset();
		t_select();
		t_divide();
		t_loss();
		t_alarm();
		t_disable();
		t_mid_reset();
		wrap_up();
	end
endmodule
